// ### rtl/cis_input_select.sv
// Input-select block of the capture/compare unit: APB registers, pin multiplexers and
// the per-channel capture/compare mode of the first timer with its coordinated update.
// Assumes pins are synchronous to pclk and that the timer core pulses period_match.
`timescale 1ns/10ps

module cis_input_select (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Port pin options.
  input wire cis_pkg::cis_pins_t pins,
  // Timer core side.
  input wire logic period_match,
  output cis_pkg::cis_mod_in_t mod_in,
  output logic [2:0] chan_mode
);

  ////////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    logic [7:0] cap_trap_sel;
    logic [7:0] pos_run_sel;
    logic [1:0] timer_b_run_sel;
    logic [2:0] mode_shadow;
    logic [2:0] mode_active;
    logic xfer_pending;
    logic trap_flag;
    cis_pkg::cis_mod_in_t mod_in;
  } cis_state_t;

  cis_state_t s_q;
  cis_state_t s_d;

  logic access;
  logic wr;
  logic mapped;
  logic [2:0] pos_mux;

  // Picks one pin option by code; a reserved code gives an inactive low input.
  function automatic logic pick(input logic [2:0] opts, input logic [1:0] code,
                                input logic [1:0] max_code);
    logic r;
    r = 1'b0;
    if (code <= max_code) begin
      r = opts[code];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // APB decode. The slave answers in the access cycle, so pready is tied high.

  assign pready = 1'b1;
  assign access = psel & penable;
  assign wr = access & pwrite & mapped;
  assign mapped = (paddr == cis_pkg::ADDR_CAP_TRAP_SEL) || (paddr == cis_pkg::ADDR_POS_RUN_SEL) ||
                  (paddr == cis_pkg::ADDR_TIMER_B_RUN_SEL) ||
                  (paddr == cis_pkg::ADDR_MODE_CTRL) || (paddr == cis_pkg::ADDR_STATUS);
  assign pslverr = access & ~mapped;

  // Read mux; the request bit is write-only and the unused bits stay zero.
  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      cis_pkg::ADDR_CAP_TRAP_SEL: prdata[7:0] = s_q.cap_trap_sel;
      cis_pkg::ADDR_POS_RUN_SEL: prdata[7:0] = s_q.pos_run_sel;
      cis_pkg::ADDR_TIMER_B_RUN_SEL: prdata[1:0] = s_q.timer_b_run_sel; // R9
      cis_pkg::ADDR_MODE_CTRL: prdata[2:0] = s_q.mode_shadow; // R1
      cis_pkg::ADDR_STATUS: begin
        prdata[2:0] = s_q.mode_active;
        prdata[cis_pkg::STAT_PENDING_BIT] = s_q.xfer_pending;
        prdata[cis_pkg::STAT_TRAP_FLAG_BIT] = s_q.trap_flag;
      end
      default: prdata = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Position input muxes, one per hall input.

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_pos
      assign pos_mux[g] = pick({1'b0, pins.pos[g]},
                               s_q.pos_run_sel[cis_pkg::POSITION0_SEL_LSB + 2 * g +: 2],
                               cis_pkg::MAX_CODE_TWO_OPT); // R7
      // Each position input: option 0, option 1, and low for the reserved codes.
      AST_POS_OPT0: assert property (@(posedge pclk) disable iff (!presetn) // R7
        (s_q.pos_run_sel[cis_pkg::POSITION0_SEL_LSB + 2 * g +: 2] == 2'h0)
        |=> mod_in.position_input[g] == $past(pins.pos[g][0]))
        else $error("position option 0 not routed");
      AST_POS_OPT1: assert property (@(posedge pclk) disable iff (!presetn) // R7
        (s_q.pos_run_sel[cis_pkg::POSITION0_SEL_LSB + 2 * g +: 2] == 2'h1)
        |=> mod_in.position_input[g] == $past(pins.pos[g][1]))
        else $error("position option 1 not routed");
      AST_POS_RES: assert property (@(posedge pclk) disable iff (!presetn) // R7
        s_q.pos_run_sel[cis_pkg::POSITION0_SEL_LSB + 2 * g + 1]
        |=> !mod_in.position_input[g])
        else $error("reserved position code not inactive");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Next state. Only module inputs are steered; output pin routing lives in the
  // port logic, so nothing here reaches a pin. R10

  always_comb begin
    s_d = s_q;
    // Register writes.
    if (wr && paddr == cis_pkg::ADDR_CAP_TRAP_SEL) begin
      s_d.cap_trap_sel = pwdata[7:0];
    end
    if (wr && paddr == cis_pkg::ADDR_POS_RUN_SEL) begin
      s_d.pos_run_sel = pwdata[7:0];
    end
    if (wr && paddr == cis_pkg::ADDR_TIMER_B_RUN_SEL) begin
      s_d.timer_b_run_sel = pwdata[1:0];
    end
    if (wr && paddr == cis_pkg::ADDR_MODE_CTRL) begin
      s_d.mode_shadow = pwdata[2:0]; // R11
    end
    // The shadow modes move to the active set only on a period match, so all three
    // channels change in the same cycle and never mid-period.
    if (s_q.xfer_pending && period_match) begin
      s_d.mode_active = s_q.mode_shadow; // R12
      s_d.xfer_pending = 1'b0;
    end
    // A request in the same cycle as the clearing match keeps the bit set. R2
    if (wr && paddr == cis_pkg::ADDR_MODE_CTRL && pwdata[cis_pkg::MODE_XFER_REQ_BIT]) begin
      s_d.xfer_pending = 1'b1;
    end
    // The trap flag is set by hardware, but a software write of the same bit wins. R2
    if (s_q.mod_in.trap_input) begin
      s_d.trap_flag = 1'b1;
    end
    if (wr && paddr == cis_pkg::ADDR_STATUS) begin
      s_d.trap_flag = pwdata[cis_pkg::STAT_TRAP_FLAG_BIT];
    end
    // Pin muxes, registered so the timer core sees glitch-free inputs. R14
    s_d.mod_in.chan_capture_in[0] = pick({2'b00, pins.cap0},
      s_q.cap_trap_sel[cis_pkg::CHAN0_CAPTURE_SEL_LSB +: 2], cis_pkg::MAX_CODE_CAP0); // R3
    s_d.mod_in.chan_capture_in[1] = pick({1'b0, pins.cap1},
      s_q.cap_trap_sel[cis_pkg::CHAN1_CAPTURE_SEL_LSB +: 2], cis_pkg::MAX_CODE_TWO_OPT); // R4
    s_d.mod_in.chan_capture_in[2] = pick({1'b0, pins.cap2},
      s_q.cap_trap_sel[cis_pkg::CHAN2_CAPTURE_SEL_LSB +: 2], cis_pkg::MAX_CODE_TWO_OPT); // R5
    s_d.mod_in.trap_input = pick(pins.trap,
      s_q.cap_trap_sel[cis_pkg::TRAP_INPUT_SEL_LSB +: 2], cis_pkg::MAX_CODE_THREE_OPT); // R6
    s_d.mod_in.position_input = pos_mux;
    s_d.mod_in.timer_a_hw_run = pick(pins.run_a,
      s_q.pos_run_sel[cis_pkg::TIMER_A_RUN_SEL_LSB +: 2], cis_pkg::MAX_CODE_THREE_OPT); // R13
    s_d.mod_in.timer_b_hw_run = pick(pins.run_b,
      s_q.timer_b_run_sel[cis_pkg::TIMER_B_RUN_SEL_LSB +: 2], cis_pkg::MAX_CODE_THREE_OPT); // R8
  end

  // State register; reset selects option 0 everywhere and compare-off modes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.cap_trap_sel <= cis_pkg::RST_SEL;
      s_q.pos_run_sel <= cis_pkg::RST_SEL;
      s_q.mode_shadow <= cis_pkg::RST_MODE;
      s_q.mode_active <= cis_pkg::RST_MODE;
    end else begin
      s_q <= s_d;
    end
  end

  assign mod_in = s_q.mod_in;
  assign chan_mode = s_q.mode_active; // R11

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_WO_READ_ZERO: assert property ( // R1
    (access && !pwrite && paddr == cis_pkg::ADDR_MODE_CTRL) |-> prdata[31:3] == 29'h0)
    else $error("write-only request bit read back nonzero");

  AST_SW_WINS: assert property ( // R2
    (wr && paddr == cis_pkg::ADDR_STATUS && !pwdata[cis_pkg::STAT_TRAP_FLAG_BIT]
     && mod_in.trap_input) |=> !s_q.trap_flag)
    else $error("hardware set overrode software clear");

  AST_CAP0: assert property ( // R3
    (s_q.cap_trap_sel[1:0] == 2'h0 && !wr) |=> mod_in.chan_capture_in[0] == $past(pins.cap0))
    else $error("channel 0 capture input not routed");

  AST_CAP1: assert property ( // R4
    (s_q.cap_trap_sel[3:2] == 2'h1) |=> mod_in.chan_capture_in[1] == $past(pins.cap1[1]))
    else $error("channel 1 option 1 not routed");

  AST_CAP2_RES: assert property ( // R5
    (s_q.cap_trap_sel[5:4] == 2'h3) |=> !mod_in.chan_capture_in[2])
    else $error("reserved channel 2 code not inactive");

  AST_TRAP: assert property ( // R6
    (s_q.cap_trap_sel[7:6] == 2'h2) |=> mod_in.trap_input == $past(pins.trap[2]))
    else $error("trap option 2 not routed");

  AST_POS2: assert property ( // R7
    (s_q.pos_run_sel[5:4] == 2'h1) |=> mod_in.position_input[2] == $past(pins.pos[2][1]))
    else $error("position 2 option 1 not routed");

  AST_RUN_B: assert property ( // R8
    (s_q.timer_b_run_sel == 2'h1) |=> mod_in.timer_b_hw_run == $past(pins.run_b[1]))
    else $error("second timer run option 1 not routed");

  AST_SEL2_ZERO: assert property ( // R9
    (access && !pwrite && paddr == cis_pkg::ADDR_TIMER_B_RUN_SEL) |-> prdata[7:2] == 6'h0)
    else $error("unused run select bits read nonzero");

  AST_MODE_HOLD: assert property ( // R12
    (!(s_q.xfer_pending && period_match)) |=> chan_mode == $past(chan_mode))
    else $error("channel modes changed outside a transfer");

  AST_MODE_XFER: assert property ( // R12
    (s_q.xfer_pending && period_match) |=> chan_mode == $past(s_q.mode_shadow) ##1
    chan_mode == $past(chan_mode))
    else $error("coordinated mode transfer wrong");

  AST_RUN_A: assert property ( // R13
    (s_q.pos_run_sel[7:6] == 2'h2) |=> mod_in.timer_a_hw_run == $past(pins.run_a[2]))
    else $error("first timer run option 2 not routed");

  // Bus side: a write lands in the addressed field only, a read shows the stored
  // fields with zeros above them, and a refused access leaves every register alone.
  AST_UNMAPPED_KEEP: assert property ( // R14
    (access && pwrite && !mapped) |=> $stable(s_q.cap_trap_sel) && $stable(s_q.pos_run_sel)
    && $stable(s_q.timer_b_run_sel) && $stable(s_q.mode_shadow))
    else $error("refused write changed a register");
  AST_UNMAPPED_RD_ZERO: assert property ( // R9
    (access && !pwrite && !mapped) |-> prdata == 32'h0000_0000)
    else $error("refused read returned data");
  AST_SEL_KEEP: assert property ( // R14
    !wr |=> $stable(s_q.cap_trap_sel) && $stable(s_q.pos_run_sel)
    && $stable(s_q.timer_b_run_sel) && $stable(s_q.mode_shadow))
    else $error("select register changed without a write");
  AST_SEL0_WRITE: assert property ( // R3
    (wr && paddr == cis_pkg::ADDR_CAP_TRAP_SEL) |=> s_q.cap_trap_sel == $past(pwdata[7:0]))
    else $error("capture select write lost");
  AST_SEL0H_WRITE: assert property ( // R7
    (wr && paddr == cis_pkg::ADDR_POS_RUN_SEL) |=> s_q.pos_run_sel == $past(pwdata[7:0]))
    else $error("position select write lost");
  AST_SEL2_WRITE: assert property ( // R8
    (wr && paddr == cis_pkg::ADDR_TIMER_B_RUN_SEL)
    |=> s_q.timer_b_run_sel == $past(pwdata[1:0]))
    else $error("second timer run select write lost");
  AST_MODE_WRITE: assert property ( // R11
    (wr && paddr == cis_pkg::ADDR_MODE_CTRL) |=> s_q.mode_shadow == $past(pwdata[2:0]))
    else $error("shadow mode write lost");
  AST_SEL0_READ: assert property ( // R3
    (access && !pwrite && paddr == cis_pkg::ADDR_CAP_TRAP_SEL)
    |-> prdata == {24'h0, s_q.cap_trap_sel})
    else $error("capture select read wrong");
  AST_SEL0H_READ: assert property ( // R7
    (access && !pwrite && paddr == cis_pkg::ADDR_POS_RUN_SEL)
    |-> prdata == {24'h0, s_q.pos_run_sel})
    else $error("position select read wrong");
  AST_SEL2_READ: assert property ( // R9
    (access && !pwrite && paddr == cis_pkg::ADDR_TIMER_B_RUN_SEL)
    |-> prdata == {30'h0, s_q.timer_b_run_sel})
    else $error("second timer run select read wrong");
  AST_MODE_READ: assert property ( // R1
    (access && !pwrite && paddr == cis_pkg::ADDR_MODE_CTRL)
    |-> prdata == {29'h0, s_q.mode_shadow})
    else $error("mode control read wrong");
  AST_STATUS_READ: assert property ( // R12
    (access && !pwrite && paddr == cis_pkg::ADDR_STATUS)
    |-> prdata == {27'h0, s_q.trap_flag, s_q.xfer_pending, s_q.mode_active})
    else $error("status read wrong");

  // Pin routing: every legal code passes its option one cycle later, and a reserved
  // code holds the module input low so a stray pin can never fire a capture or trap.
  AST_CAP0_RES: assert property ( // R3
    (s_q.cap_trap_sel[1:0] != 2'h0) |=> !mod_in.chan_capture_in[0])
    else $error("reserved channel 0 code not inactive");
  AST_CAP1_OPT0: assert property ( // R4
    (s_q.cap_trap_sel[3:2] == 2'h0) |=> mod_in.chan_capture_in[1] == $past(pins.cap1[0]))
    else $error("channel 1 option 0 not routed");
  AST_CAP1_RES: assert property ( // R4
    s_q.cap_trap_sel[3] |=> !mod_in.chan_capture_in[1])
    else $error("reserved channel 1 code not inactive");
  AST_CAP2_OPT0: assert property ( // R5
    (s_q.cap_trap_sel[5:4] == 2'h0) |=> mod_in.chan_capture_in[2] == $past(pins.cap2[0]))
    else $error("channel 2 option 0 not routed");
  AST_CAP2_OPT1: assert property ( // R5
    (s_q.cap_trap_sel[5:4] == 2'h1) |=> mod_in.chan_capture_in[2] == $past(pins.cap2[1]))
    else $error("channel 2 option 1 not routed");
  AST_TRAP_OPT0: assert property ( // R6
    (s_q.cap_trap_sel[7:6] == 2'h0) |=> mod_in.trap_input == $past(pins.trap[0]))
    else $error("trap option 0 not routed");
  AST_TRAP_OPT1: assert property ( // R6
    (s_q.cap_trap_sel[7:6] == 2'h1) |=> mod_in.trap_input == $past(pins.trap[1]))
    else $error("trap option 1 not routed");
  AST_TRAP_RES: assert property ( // R6
    (s_q.cap_trap_sel[7:6] == 2'h3) |=> !mod_in.trap_input)
    else $error("reserved trap code not inactive");
  AST_RUN_A_OPT0: assert property ( // R13
    (s_q.pos_run_sel[7:6] == 2'h0) |=> mod_in.timer_a_hw_run == $past(pins.run_a[0]))
    else $error("first timer run option 0 not routed");
  AST_RUN_A_OPT1: assert property ( // R13
    (s_q.pos_run_sel[7:6] == 2'h1) |=> mod_in.timer_a_hw_run == $past(pins.run_a[1]))
    else $error("first timer run option 1 not routed");
  AST_RUN_A_RES: assert property ( // R13
    (s_q.pos_run_sel[7:6] == 2'h3) |=> !mod_in.timer_a_hw_run)
    else $error("reserved first timer run code not inactive");
  AST_RUN_B_OPT0: assert property ( // R8
    (s_q.timer_b_run_sel == 2'h0) |=> mod_in.timer_b_hw_run == $past(pins.run_b[0]))
    else $error("second timer run option 0 not routed");
  AST_RUN_B_OPT2: assert property ( // R8
    (s_q.timer_b_run_sel == 2'h2) |=> mod_in.timer_b_hw_run == $past(pins.run_b[2]))
    else $error("second timer run option 2 not routed");
  AST_RUN_B_RES: assert property ( // R8
    (s_q.timer_b_run_sel == 2'h3) |=> !mod_in.timer_b_hw_run)
    else $error("reserved second timer run code not inactive");

  // Transfer request and trap flag: hardware sets or clears them, but a software
  // write in the same cycle always has the last word.
  AST_PEND_SET: assert property ( // R2
    (wr && paddr == cis_pkg::ADDR_MODE_CTRL && pwdata[cis_pkg::MODE_XFER_REQ_BIT]) |=> s_q.xfer_pending)
    else $error("transfer request lost");
  AST_PEND_CLR: assert property ( // R12
    (s_q.xfer_pending && period_match && !(wr && paddr == cis_pkg::ADDR_MODE_CTRL))
    |=> !s_q.xfer_pending)
    else $error("pending not cleared by the transfer");
  AST_PEND_KEEP: assert property ( // R12
    (s_q.xfer_pending && !period_match) |=> s_q.xfer_pending)
    else $error("pending dropped without a match");
  AST_PEND_IDLE: assert property ( // R12
    (!s_q.xfer_pending && !(wr && paddr == cis_pkg::ADDR_MODE_CTRL))
    |=> !s_q.xfer_pending)
    else $error("pending set without a request");
  AST_TRAP_SET: assert property ( // R2
    (mod_in.trap_input && !(wr && paddr == cis_pkg::ADDR_STATUS))
    |=> s_q.trap_flag)
    else $error("trap flag not set by the trap input");
  AST_TRAP_KEEP: assert property ( // R2
    (s_q.trap_flag && !(wr && paddr == cis_pkg::ADDR_STATUS)) |=> s_q.trap_flag)
    else $error("trap flag dropped without a write");
  AST_TRAP_WRITE: assert property ( // R2
    (wr && paddr == cis_pkg::ADDR_STATUS)
    |=> s_q.trap_flag == $past(pwdata[cis_pkg::STAT_TRAP_FLAG_BIT]))
    else $error("trap flag write lost");

  COV_XFER: cover property (s_q.xfer_pending ##[1:20] (period_match && s_q.xfer_pending));
  COV_TRAP_SET: cover property (!s_q.trap_flag ##1 s_q.trap_flag);
  COV_UNMAPPED: cover property (pslverr);
  COV_RACE: cover property (s_q.xfer_pending && period_match && wr &&
    paddr == cis_pkg::ADDR_MODE_CTRL);
  COV_SW_CLEAR: cover property (wr && paddr == cis_pkg::ADDR_STATUS && mod_in.trap_input);

endmodule

// ### rtl/cis_pkg.sv
// Package of the capture/compare input-select block: register map, field layout,
// reset values and the carrier structs for the pin and module-input groups.
// Assumes an APB slave with 32-bit data and one aligned word per register.
//
// Functional notes
// R1: Write-only bit positions always read back as zero.
// R2: When hardware and software change the same bit in one cycle, the software value is kept.
// R3: The channel-0 capture select in bits 1:0 routes pin option 0 for code 00; other codes are reserved.
// R4: The channel-1 capture select in bits 3:2 routes option 0 for 00 and option 1 for 01.
// R5: The channel-2 capture select in bits 5:4 routes option 0 for 00 and option 1 for 01.
// R6: The trap select in bits 7:6 routes options 0, 1, 2 for codes 00, 01, 10; 11 is reserved.
// R7: Each position select (bits 1:0, 3:2, 5:4 of the high register) routes option 0 or 1.
// R8: The second timer run select in bits 1:0 routes options 0, 1, 2 for codes 00, 01, 10.
// R9: Bits 7:2 of the second timer run select register read as zero.
// R10: The block only steers module inputs and never drives or selects output pins.
// R11: The first timer has three channels, each set to capture or compare on its own.
// R12: The channel modes of the first timer change together, on a defined transfer event.
// R13: The first timer run select in bits 7:6 routes options 0, 1, 2 for codes 00, 01, 10.
// R14: Each selected pin reaches its module input through a mux driven by the current field.
package cis_pkg;

  // Byte addresses of the registers.
  localparam logic [7:0] ADDR_CAP_TRAP_SEL = 8'h00;
  localparam logic [7:0] ADDR_POS_RUN_SEL = 8'h04;
  localparam logic [7:0] ADDR_TIMER_B_RUN_SEL = 8'h08;
  localparam logic [7:0] ADDR_MODE_CTRL = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // Field positions (low bit of each two-bit select field, and the single request and status bits).
  localparam int CHAN0_CAPTURE_SEL_LSB = 0;
  localparam int CHAN1_CAPTURE_SEL_LSB = 2;
  localparam int CHAN2_CAPTURE_SEL_LSB = 4;
  localparam int TRAP_INPUT_SEL_LSB = 6;
  localparam int POSITION0_SEL_LSB = 0;
  localparam int TIMER_A_RUN_SEL_LSB = 6;
  localparam int TIMER_B_RUN_SEL_LSB = 0;
  localparam int MODE_XFER_REQ_BIT = 3;
  localparam int STAT_PENDING_BIT = 3;
  localparam int STAT_TRAP_FLAG_BIT = 4;

  // Highest legal code per field; anything above is reserved.
  localparam logic [1:0] MAX_CODE_CAP0 = 2'h0;
  localparam logic [1:0] MAX_CODE_TWO_OPT = 2'h1;
  localparam logic [1:0] MAX_CODE_THREE_OPT = 2'h2;

  // Reset values.
  localparam logic [7:0] RST_SEL = 8'h00;
  localparam logic [2:0] RST_MODE = 3'h0;

  // Port pin options offered to each module input.
  typedef struct packed {
    logic cap0;
    logic [1:0] cap1;
    logic [1:0] cap2;
    logic [2:0] trap;
    logic [2:0][1:0] pos;
    logic [2:0] run_a;
    logic [2:0] run_b;
  } cis_pins_t;

  // Selected module inputs handed to the timer core.
  typedef struct packed {
    logic [2:0] chan_capture_in;
    logic trap_input;
    logic [2:0] position_input;
    logic timer_a_hw_run;
    logic timer_b_hw_run;
  } cis_mod_in_t;

endpackage

// ### test/cis_pin_model.sv
// Partner model: port pin options and the timer core period match pulse.
// Assumes the bench sets the wanted pin levels and match request after pclk edges.
`timescale 1ns/10ps

module cis_pin_model (
  // Clock.
  input wire logic pclk,
  // Bench requests.
  input wire cis_pkg::cis_pins_t pin_set,
  input wire logic match_req,
  // Towards the block.
  output cis_pkg::cis_pins_t pins,
  output logic period_match
);
  // Pins and match change only after an edge, so the block never sees a mid-cycle glitch.
  always_ff @(posedge pclk) begin
    pins <= pin_set;
    period_match <= match_req;
  end
endmodule

// ### test/test_cis_input_select.sv
// Self-checking bench of the input-select block with APB master tasks.
// Assumes the pin model answers one cycle after each request and pready is sampled.
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end

module test_cis_input_select;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, match_req = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, period_match;
  logic [2:0] chan_mode;
  cis_pkg::cis_pins_t pin_set = '0, pins;
  cis_pkg::cis_mod_in_t mod_in;
  int bad_count = 0, num_checks = 0;

  // Clock of 5 ns.
  always #2.5 pclk = ~pclk;

  cis_input_select cis_input_select_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(pins), .period_match(period_match),
    .mod_in(mod_in), .chan_mode(chan_mode));
  cis_pin_model cis_pin_model_inst (.pclk(pclk), .pin_set(pin_set), .match_req(match_req),
    .pins(pins), .period_match(period_match));

  ////////////////////////////////////////////////////////////////////////////////
  // One APB transfer; m raises period match in the very cycle of the access phase.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic m);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    match_req <= m;
    @(posedge pclk);
    penable <= 1'b1;
    match_req <= 1'b0;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Set pins, write a select register and let the two-cycle path settle.
  task automatic sel(input logic [7:0] a, input logic [7:0] v, input cis_pkg::cis_pins_t p);
    pin_set <= p;
    apb(1'b1, a, {24'h0, v}, 1'b0);
    repeat (3) @(posedge pclk);
  endtask

  // One-cycle period match pulse, then time for the transfer to land.
  task automatic pulse;
    @(posedge pclk);
    match_req <= 1'b1;
    @(posedge pclk);
    match_req <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Every register reads zero after reset; the unmapped word is refused.
  task automatic t_reset;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0, 1'b0);
      `CHK(rd, 32'h0)
    end
    apb(1'b0, 8'h14, 32'h0, 1'b0);
    `CHK({err, rd}, {1'b1, 32'h0})
    $display("reset test done");
  endtask

  // Modes load only on a match, all three channels together, and the request bit reads zero.
  task automatic t_mode;
    apb(1'b1, 8'h0c, 32'h0000000d, 1'b0);
    apb(1'b0, 8'h0c, 32'h0, 1'b0);
    `CHK(rd, 32'h00000005)
    apb(1'b0, 8'h10, 32'h0, 1'b0);
    `CHK(rd, 32'h00000008)
    `CHK(chan_mode, 3'h0)
    pulse();
    `CHK(chan_mode, 3'h5)
    apb(1'b0, 8'h10, 32'h0, 1'b0);
    `CHK(rd, 32'h00000005)
    $display("mode test done");
  endtask

  // A request that meets a match while pending moves the old shadow and stays pending.
  task automatic t_race;
    apb(1'b1, 8'h0c, 32'h0000000b, 1'b0);
    apb(1'b1, 8'h0c, 32'h0000000a, 1'b1);
    apb(1'b0, 8'h10, 32'h0, 1'b0);
    `CHK(rd, 32'h0000000b)
    `CHK(chan_mode, 3'h3)
    pulse();
    `CHK(chan_mode, 3'h2)
    $display("race test done");
  endtask

  // Capture and trap selects, reserved codes included.
  task automatic t_cap;
    sel(8'h00, 8'h95, {1'b1, 2'b10, 2'b10, 3'b100, 6'h0, 3'h0, 3'h0});
    `CHK({mod_in.chan_capture_in, mod_in.trap_input}, 4'b1101)
    apb(1'b1, 8'h10, 32'h0, 1'b0);
    sel(8'h00, 8'h00, {1'b1, 2'b10, 2'b10, 3'b100, 6'h0, 3'h0, 3'h0});
    `CHK({mod_in.chan_capture_in, mod_in.trap_input}, 4'b0010)
    sel(8'h00, 8'hf0, {1'b0, 2'b00, 2'b11, 3'b111, 6'h0, 3'h0, 3'h0});
    `CHK({mod_in.chan_capture_in[2], mod_in.trap_input}, 2'b00)
    apb(1'b0, 8'h10, 32'h0, 1'b0);
    `CHK(rd, 32'h00000012)
    apb(1'b1, 8'h10, 32'h0, 1'b0);
    apb(1'b0, 8'h10, 32'h0, 1'b0);
    `CHK(rd, 32'h00000002)
    $display("capture test done");
  endtask

  // Position and first timer run selects.
  task automatic t_pos;
    sel(8'h04, 8'ha4, {8'h0, 6'b11_10_01, 3'b100, 3'h0});
    `CHK({mod_in.position_input, mod_in.timer_a_hw_run}, 4'b0111)
    sel(8'h04, 8'h50, {8'h0, 6'b10_00_01, 3'b100, 3'h0});
    `CHK({mod_in.position_input, mod_in.timer_a_hw_run}, 4'b1010)
    $display("position test done");
  endtask

  // Second timer run select over all codes, then the unused bits.
  task automatic t_runb;
    for (int c = 0; c < 4; c++) begin
      sel(8'h08, 8'(c), {14'h0, 3'h0, (c < 3) ? 3'(1 << c) : 3'b111});
      `CHK(mod_in.timer_b_hw_run, (c < 3))
    end
    apb(1'b1, 8'h08, 32'h000000fd, 1'b0);
    apb(1'b0, 8'h08, 32'h0, 1'b0);
    `CHK(rd, 32'h00000001)
    $display("run select test done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then stops.
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Main sequence after a reset of four cycles.
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_mode();
    t_race();
    t_cap();
    t_pos();
    t_runb();
    end_of_test();
  end

  // Watchdog; the tests need well under a thousand cycles.
  initial begin
    #20000;
    bad_count++;
    end_of_test();
  end
endmodule
